// [design/tbg_tone_ring_buzzer.sv]
`timescale 1ns/1ps
module tbg_tone_ring_buzzer (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // Serial control port
  input  wire logic               ctl_clk,
  input  wire logic               ctl_cs_n,
  input  wire logic               ctl_din,
  output logic                    ctl_dout,
  output logic                    ctl_dout_oe,
  // Master clock
  input  wire logic               mclk,
  input  wire logic [1:0]         mclk_sel,
  // Power
  input  wire logic               pwr_down,
  // Audio samples
  input  wire logic signed [15:0] tx_amp_sample,
  output logic signed [15:0]      tone_sample,
  output logic signed [15:0]      tx_path_sample,
  // Buzzer
  output logic                    buzzer_out
);
  import tbg_pkg::*;

  typedef enum {TBG_SP_IDLE, TBG_SP_CMD, TBG_SP_DATA, TBG_SP_DONE} tbg_sp_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] ctl_clk_sync;
  logic [1:0] ctl_cs_sync;
  logic [1:0] ctl_din_sync;
  logic [1:0] mclk_sync;
  logic       ctl_clk_d;
  logic       mclk_d;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl_clk_sync <= 2'h0;
      ctl_cs_sync  <= 2'h3;
      ctl_din_sync <= 2'h0;
      mclk_sync    <= 2'h0;
      ctl_clk_d    <= 1'b0;
      mclk_d       <= 1'b0;
    end else begin
      ctl_clk_sync <= {ctl_clk_sync[0], ctl_clk};
      ctl_cs_sync  <= {ctl_cs_sync[0], ctl_cs_n};
      ctl_din_sync <= {ctl_din_sync[0], ctl_din};
      mclk_sync    <= {mclk_sync[0], mclk};
      ctl_clk_d    <= ctl_clk_sync[1];
      mclk_d       <= mclk_sync[1];
    end
  end

  logic ctl_rise;
  logic ctl_fall;
  logic cs_active;
  logic mclk_rise;
  assign ctl_rise  = ctl_clk_sync[1] && !ctl_clk_d;
  assign ctl_fall  = !ctl_clk_sync[1] && ctl_clk_d;
  assign cs_active = !ctl_cs_sync[1];
  assign mclk_rise = mclk_sync[1] && !mclk_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial port and register file
  tbg_sp_state_t sp_state_reg, sp_state_next;
  logic [2:0]    bit_cnt_reg, bit_cnt_next;
  logic [7:0]    shift_in_reg, shift_in_next;
  logic [7:0]    shift_out_reg, shift_out_next;
  logic [7:0]    cmd_reg, cmd_next;
  logic          dout_reg, dout_next;
  logic          dout_oe_reg, dout_oe_next;
  logic [7:0]    tone_control_reg, tone_control_next;
  logic [7:0]    first_tone_frequency_reg, first_tone_frequency_next;
  logic [7:0]    second_tone_frequency_reg, second_tone_frequency_next;
  logic [1:0]    tone_range_select_reg, tone_range_select_next;
  logic [7:0]    buzzer_control_reg, buzzer_control_next;
  logic [7:0]    in_byte;
  logic [7:0]    rd_data;

  always_comb begin
    case (shift_in_next[CMD_ADDR_MSB:0])
      REG_TONE_CONTROL:     rd_data = tone_control_reg;
      REG_FIRST_TONE_FREQ:  rd_data = first_tone_frequency_reg;
      REG_SECOND_TONE_FREQ: rd_data = second_tone_frequency_reg;
      REG_TONE_RANGE_SEL:   rd_data = {6'h00, tone_range_select_reg};
      REG_BUZZER_CONTROL:   rd_data = buzzer_control_reg;
      default:              rd_data = 8'h00;
    endcase
  end

  always_comb begin
    sp_state_next              = sp_state_reg;
    bit_cnt_next               = bit_cnt_reg;
    shift_in_next              = shift_in_reg;
    shift_out_next             = shift_out_reg;
    cmd_next                   = cmd_reg;
    dout_next                  = dout_reg;
    dout_oe_next               = dout_oe_reg;
    tone_control_next          = tone_control_reg;
    first_tone_frequency_next  = first_tone_frequency_reg;
    second_tone_frequency_next = second_tone_frequency_reg;
    tone_range_select_next     = tone_range_select_reg;
    buzzer_control_next        = buzzer_control_reg;
    in_byte                    = {shift_in_reg[6:0], ctl_din_sync[1]};
    if (ctl_rise) begin
      shift_in_next = in_byte;
    end
    if (!cs_active) begin
      sp_state_next = TBG_SP_IDLE;
      dout_oe_next  = 1'b0;
    end else begin
      case (sp_state_reg)
        TBG_SP_IDLE: begin
          sp_state_next = TBG_SP_CMD;
          bit_cnt_next  = 3'h0;
        end
        TBG_SP_CMD: begin
          if (ctl_rise) begin
            bit_cnt_next = 3'(bit_cnt_reg + 3'h1);
            if (bit_cnt_reg == 3'h7) begin
              cmd_next       = in_byte;
              shift_out_next = rd_data;
              sp_state_next  = TBG_SP_DATA;
            end
          end
        end
        TBG_SP_DATA: begin
          if (ctl_fall && cmd_reg[CMD_READ_BIT]) begin
            dout_next      = shift_out_reg[7];
            dout_oe_next   = 1'b1;
            shift_out_next = {shift_out_reg[6:0], 1'b0};
          end
          if (ctl_rise) begin
            bit_cnt_next = 3'(bit_cnt_reg + 3'h1);
            if (bit_cnt_reg == 3'h7) begin
              sp_state_next = TBG_SP_DONE;
              if (!cmd_reg[CMD_READ_BIT]) begin
                case (cmd_reg[CMD_ADDR_MSB:0])
                  REG_TONE_CONTROL:     tone_control_next          = in_byte;
                  REG_FIRST_TONE_FREQ:  first_tone_frequency_next  = in_byte;
                  REG_SECOND_TONE_FREQ: second_tone_frequency_next = in_byte;
                  REG_TONE_RANGE_SEL:   tone_range_select_next     = in_byte[RS_DOUBLE_SEL:RS_HALF_SEL];
                  REG_BUZZER_CONTROL:   buzzer_control_next        = in_byte;
                  default:              tone_control_next          = tone_control_reg;
                endcase
              end
            end
          end
        end
        TBG_SP_DONE: begin
          // Extra clocks after a transfer are ignored until select drops
          if (ctl_fall) begin
            dout_oe_next = 1'b0;
          end
        end
        default: sp_state_next = TBG_SP_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sp_state_reg              <= TBG_SP_IDLE;
      bit_cnt_reg               <= 3'h0;
      shift_in_reg              <= 8'h00;
      shift_out_reg             <= 8'h00;
      cmd_reg                   <= 8'h00;
      dout_reg                  <= 1'b0;
      dout_oe_reg               <= 1'b0;
      tone_control_reg          <= TONE_CONTROL_RST;
      first_tone_frequency_reg  <= TONE_FREQ_RST;
      second_tone_frequency_reg <= TONE_FREQ_RST;
      tone_range_select_reg     <= RANGE_SEL_RST;
      buzzer_control_reg        <= BUZZER_CTRL_RST;
    end else begin
      sp_state_reg              <= sp_state_next;
      bit_cnt_reg               <= bit_cnt_next;
      shift_in_reg              <= shift_in_next;
      shift_out_reg             <= shift_out_next;
      cmd_reg                   <= cmd_next;
      dout_reg                  <= dout_next;
      dout_oe_reg               <= dout_oe_next;
      tone_control_reg          <= tone_control_next;
      first_tone_frequency_reg  <= first_tone_frequency_next;
      second_tone_frequency_reg <= second_tone_frequency_next;
      tone_range_select_reg     <= tone_range_select_next;
      buzzer_control_reg        <= buzzer_control_next;
    end
  end

  assign ctl_dout    = dout_reg;
  assign ctl_dout_oe = dout_oe_reg;

  // Decoded controls; cadence comes only from host writes
  logic       first_gen_select;
  logic       second_gen_select;
  logic       waveform_select;
  logic       tx_path_inject;
  logic       range_double_sel;
  logic       range_half_sel;
  logic       buzzer_enable;
  logic       buzzer_polarity;
  logic [3:0] atten_code;
  logic [5:0] duty;
  assign first_gen_select  = tone_control_reg[TC_FIRST_SEL];
  assign second_gen_select = tone_control_reg[TC_SECOND_SEL];
  assign waveform_select   = tone_control_reg[TC_WAVE_SEL];
  assign tx_path_inject    = tone_control_reg[TC_TX_INJECT];
  assign atten_code        = tone_control_reg[TC_ATTEN_MSB:TC_ATTEN_LSB];
  assign range_double_sel  = tone_range_select_reg[RS_DOUBLE_SEL];
  assign range_half_sel    = tone_range_select_reg[RS_HALF_SEL];
  assign buzzer_enable     = buzzer_control_reg[BZ_ENABLE];
  assign buzzer_polarity   = buzzer_control_reg[BZ_POLARITY];
  assign duty              = buzzer_control_reg[BZ_DUTY_MSB:BZ_DUTY_LSB];

  ////////////////////////////////////////////////////////////////////////////////
  // Master clock divider to a 512 kHz base tick
  logic [2:0] div_cnt_reg, div_cnt_next;
  logic       half_phase_reg, half_phase_next;
  logic [2:0] div_ratio;
  logic       base_tick;
  logic       gen_tick;
  logic       is_double;
  logic       is_half;

  assign is_double = range_double_sel && !range_half_sel;
  assign is_half   = range_half_sel && !range_double_sel;

  always_comb begin
    case (mclk_sel)
      2'h0:    div_ratio = MCLK0_DIV;
      2'h1:    div_ratio = MCLK1_DIV;
      2'h2:    div_ratio = MCLK2_DIV;
      default: div_ratio = MCLK3_DIV;
    endcase
    base_tick       = mclk_rise && (div_cnt_reg >= 3'(div_ratio - 3'h1));
    div_cnt_next    = div_cnt_reg;
    half_phase_next = half_phase_reg;
    if (mclk_rise) begin
      div_cnt_next = base_tick ? 3'h0 : 3'(div_cnt_reg + 3'h1);
    end
    if (base_tick) begin
      half_phase_next = !half_phase_reg;
    end
    gen_tick = base_tick && (!is_half || half_phase_reg);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_cnt_reg    <= 3'h0;
      half_phase_reg <= 1'b0;
    end else begin
      div_cnt_reg    <= div_cnt_next;
      half_phase_reg <= half_phase_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Two generators; doubled range steps twice as far per tick
  logic [ACC_W-1:0]  step1;
  logic [ACC_W-1:0]  step2;
  logic              sq1;
  logic              sq2;
  logic signed [7:0] sine1;
  logic signed [7:0] sine2;

  assign step1 = is_double ? {7'h00, first_tone_frequency_reg, 1'b0} : {8'h00, first_tone_frequency_reg};
  assign step2 = is_double ? {7'h00, second_tone_frequency_reg, 1'b0} : {8'h00, second_tone_frequency_reg};

  tbg_tone_gen #(.ACC_BITS(ACC_W)) u_first_generator (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .run        (first_gen_select),
    .tick_en    (gen_tick),
    .step       (step1),
    .square_out (sq1),
    .sine_out   (sine1)
  );

  tbg_tone_gen #(.ACC_BITS(ACC_W)) u_second_generator (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .run        (second_gen_select),
    .tick_en    (gen_tick),
    .step       (step2),
    .square_out (sq2),
    .sine_out   (sine2)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Mixer, attenuator and transmit routing
  logic signed [15:0] tone_next;
  logic signed [15:0] tx_path_next;
  logic signed [7:0]  s1;
  logic signed [7:0]  s2;
  logic signed [17:0] mix;
  logic signed [26:0] atten_prod;

  always_comb begin
    // Natural shape: first square, second sine; waveform bit forces sine on both
    s1 = 8'sh00;
    s2 = 8'sh00;
    if (first_gen_select) begin
      s1 = waveform_select ? sine1 : (sq1 ? SQUARE_HIGH : SQUARE_LOW);
    end
    if (second_gen_select) begin
      s2 = sine2;
    end
    mix          = 18'(s1) * F1_GAIN_Q8 + 18'(s2) * F2_GAIN_Q8;
    atten_prod   = 27'(mix) * 27'($signed({1'b0, tbg_atten_gain(atten_code)}));
    tone_next    = atten_prod[24:9];
    tx_path_next = tx_path_inject ? tone_sample : tx_amp_sample;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tone_sample    <= 16'sh0000;
      tx_path_sample <= 16'sh0000;
    end else begin
      tone_sample    <= tone_next;
      tx_path_sample <= tx_path_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Buzzer PWM; duty tops out below half period with six bits
  logic [PWM_W-1:0] pwm_cnt_reg, pwm_cnt_next;
  logic             buzzer_next;
  logic             pwm_on;
  logic             ring_gate;
  logic             buzz_live;

  always_comb begin
    pwm_cnt_next = base_tick ? PWM_W'(pwm_cnt_reg + 1'b1) : pwm_cnt_reg;
    pwm_on       = pwm_cnt_reg < {1'b0, duty};
    ring_gate    = sq1 && (!second_gen_select || sq2);
    buzz_live    = buzzer_enable && !pwr_down && first_gen_select;
    buzzer_next  = buzz_live ? ((pwm_on && ring_gate) ^ buzzer_polarity) : buzzer_polarity;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwm_cnt_reg <= '0;
      buzzer_out  <= 1'b0;
    end else begin
      pwm_cnt_reg <= pwm_cnt_next;
      buzzer_out  <= buzzer_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_idle_level: assert property (@(posedge sys_clk) disable iff (rst)
    (!buzzer_enable || pwr_down) |=> buzzer_out == $past(buzzer_polarity))
    else $error("buzzer not at idle level");

  a_pwm_off_part: assert property (@(posedge sys_clk) disable iff (rst)
    (pwm_cnt_reg >= {1'b0, duty}) |=> buzzer_out == $past(buzzer_polarity))
    else $error("buzzer active outside duty window");

  a_pwm_on_part: assert property (@(posedge sys_clk) disable iff (rst)
    (buzz_live && pwm_cnt_reg < {1'b0, duty} && sq1 && !second_gen_select)
      |=> buzzer_out == !$past(buzzer_polarity))
    else $error("buzzer not active inside duty window");

  a_am_gate: assert property (@(posedge sys_clk) disable iff (rst)
    (second_gen_select && !sq2) |=> buzzer_out == $past(buzzer_polarity))
    else $error("buzzer not gated by second generator");

  a_reset_buzzer: assert property (@(posedge sys_clk)
    $fell(rst) |-> !buzzer_control_reg[BZ_ENABLE] && !buzzer_control_reg[BZ_POLARITY] && !buzzer_out)
    else $error("buzzer control not cleared at reset");

  a_half_skip: assert property (@(posedge sys_clk) disable iff (rst)
    (is_half && base_tick && !half_phase_reg) |-> !gen_tick)
    else $error("halved range ticked every base tick");

  a_double_step: assert property (@(posedge sys_clk) disable iff (rst)
    (is_double && gen_tick && first_gen_select && first_tone_frequency_reg != 8'h00)
      |=> u_first_generator.acc_reg ==
          ACC_W'($past(u_first_generator.acc_reg) + {$past(first_tone_frequency_reg), 1'b0}))
    else $error("doubled range step wrong");

  a_tx_route: assert property (@(posedge sys_clk) disable iff (rst)
    (!tx_path_inject) [*2] |-> tx_path_sample == $past(tx_amp_sample))
    else $error("transmit path not from amplifier");

  a_silent_off: assert property (@(posedge sys_clk) disable iff (rst)
    (!first_gen_select && !second_gen_select) [*2] |-> tone_sample == 16'sh0000)
    else $error("tone present with no generator");

  a_dout_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    (!cs_active) |=> !ctl_dout_oe)
    else $error("serial output driven while deselected");

endmodule

// [inc/tbg_pkg.sv]
package tbg_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register numbers, carried in the low nibble of the command byte
  localparam logic [3:0] REG_TONE_CONTROL    = 4'h7;
  localparam logic [3:0] REG_FIRST_TONE_FREQ  = 4'h8;
  localparam logic [3:0] REG_SECOND_TONE_FREQ = 4'h9;
  localparam logic [3:0] REG_TONE_RANGE_SEL   = 4'hA;
  localparam logic [3:0] REG_BUZZER_CONTROL   = 4'hB;
  localparam int         CMD_READ_BIT         = 7;
  localparam int         CMD_ADDR_MSB         = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int TC_ATTEN_MSB   = 7;
  localparam int TC_ATTEN_LSB   = 4;
  localparam int TC_FIRST_SEL   = 3;
  localparam int TC_SECOND_SEL  = 2;
  localparam int TC_WAVE_SEL    = 1;
  localparam int TC_TX_INJECT   = 0;
  localparam int RS_DOUBLE_SEL  = 1;
  localparam int RS_HALF_SEL    = 0;
  localparam int BZ_ENABLE      = 7;
  localparam int BZ_POLARITY    = 6;
  localparam int BZ_DUTY_MSB    = 5;
  localparam int BZ_DUTY_LSB    = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] TONE_CONTROL_RST = 8'h00;
  localparam logic [7:0] TONE_FREQ_RST    = 8'h00;
  localparam logic [1:0] RANGE_SEL_RST    = 2'h0;
  localparam logic [7:0] BUZZER_CTRL_RST  = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing: base tick of 512 kHz against a 16-bit phase accumulator
  localparam int         BASE_TICK_KHZ = 512;
  localparam int         MCLK0_KHZ     = 512;
  localparam int         MCLK1_KHZ     = 1536;
  localparam int         MCLK2_KHZ     = 2048;
  localparam int         MCLK3_KHZ     = 2560;
  localparam logic [2:0] MCLK0_DIV     = 3'(MCLK0_KHZ / BASE_TICK_KHZ);
  localparam logic [2:0] MCLK1_DIV     = 3'(MCLK1_KHZ / BASE_TICK_KHZ);
  localparam logic [2:0] MCLK2_DIV     = 3'(MCLK2_KHZ / BASE_TICK_KHZ);
  localparam logic [2:0] MCLK3_DIV     = 3'(MCLK3_KHZ / BASE_TICK_KHZ);
  localparam int         ACC_W         = 16;
  localparam int         PWM_W         = 7;

  ////////////////////////////////////////////////////////////////////////////////
  // Levels, Q8 gains
  localparam logic signed [17:0] F1_GAIN_Q8     = 18'sh00100;
  localparam logic signed [17:0] F2_GAIN_Q8     = 18'sh000CB;
  localparam logic signed [7:0]  SQUARE_HIGH    = 8'sh7F;
  localparam logic signed [7:0]  SQUARE_LOW     = -8'sh7F;
  localparam logic [3:0]         ATTEN_MAX_CODE = 4'h9;

  function automatic logic [8:0] tbg_atten_gain(input logic [3:0] code);
    logic [8:0] g;
    g = 9'h00B;
    case (code)
      4'h0:    g = 9'h100;
      4'h1:    g = 9'h0B5;
      4'h2:    g = 9'h080;
      4'h3:    g = 9'h05B;
      4'h4:    g = 9'h040;
      4'h5:    g = 9'h02D;
      4'h6:    g = 9'h020;
      4'h7:    g = 9'h017;
      4'h8:    g = 9'h010;
      default: g = 9'h00B;
    endcase
    return g;
  endfunction

  function automatic logic [6:0] tbg_sine_quarter(input logic [3:0] idx);
    logic [6:0] v;
    v = 7'h00;
    case (idx)
      4'h0:    v = 7'h06;
      4'h1:    v = 7'h13;
      4'h2:    v = 7'h1F;
      4'h3:    v = 7'h2B;
      4'h4:    v = 7'h36;
      4'h5:    v = 7'h41;
      4'h6:    v = 7'h4C;
      4'h7:    v = 7'h55;
      4'h8:    v = 7'h5E;
      4'h9:    v = 7'h66;
      4'hA:    v = 7'h6D;
      4'hB:    v = 7'h73;
      4'hC:    v = 7'h78;
      4'hD:    v = 7'h7B;
      4'hE:    v = 7'h7E;
      default: v = 7'h7F;
    endcase
    return v;
  endfunction

endpackage

// [design/tbg_tone_gen.sv]
`timescale 1ns/1ps
module tbg_tone_gen #(
  parameter int ACC_BITS = 16
) (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // Control
  input  wire logic                run,
  input  wire logic                tick_en,
  input  wire logic [ACC_BITS-1:0] step,
  // Waveforms
  output logic                     square_out,
  output logic signed [7:0]        sine_out
);
  import tbg_pkg::*;

  logic [ACC_BITS-1:0] acc_reg;
  logic [ACC_BITS-1:0] acc_next;
  logic                square_next;
  logic signed [7:0]   sine_next;
  logic [1:0]          quad;
  logic [3:0]          idx;
  logic [6:0]          mag;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    acc_next = acc_reg;
    if (!run || step == '0) begin
      acc_next = '0;
    end else if (tick_en) begin
      acc_next = ACC_BITS'(acc_reg + step);
    end
    quad        = acc_next[ACC_BITS-1 -: 2];
    idx         = acc_next[ACC_BITS-3 -: 4];
    mag         = tbg_sine_quarter(quad[0] ? ~idx : idx);
    square_next = acc_next[ACC_BITS-1];
    sine_next   = quad[1] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_reg    <= '0;
      square_out <= 1'b0;
      sine_out   <= 8'sh00;
    end else begin
      acc_reg    <= acc_next;
      square_out <= square_next;
      sine_out   <= sine_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_acc_advance: assert property (@(posedge sys_clk) disable iff (rst)
    (run && tick_en && step != '0) |=> acc_reg == ACC_BITS'($past(acc_reg) + $past(step)))
    else $error("accumulator did not advance by step");

  a_zero_still: assert property (@(posedge sys_clk) disable iff (rst)
    (step == '0) [*2] |-> acc_reg == '0 && !square_out)
    else $error("zero frequency still oscillates");

endmodule

// [dv/tbg_far_side.sv]
`timescale 1ns/1ps
module tbg_far_side #(
  parameter int MCLK_HALF_NS = 200
) (
  // Master clock
  output logic     mclk,
  // Buzzer pin, load only
  input  wire logic buzzer_out
);
  initial mclk = 1'b0;
  // Free running and fast with divider 1, so PWM periods stay short
  always #(MCLK_HALF_NS) mclk = ~mclk;
endmodule

// [dv/tbg_tone_ring_buzzer_tb.sv]
`timescale 1ns/1ps
module tbg_tone_ring_buzzer_tb;
  import tbg_pkg::*;
  logic               sys_clk = 0, rst = 1, ctl_clk = 0, ctl_cs_n = 1, ctl_din = 0, pwr_down = 0;
  logic [1:0]         mclk_sel = 2'h0;
  logic signed [15:0] tx_amp_sample = 16'sh0000;
  logic               ctl_dout, ctl_dout_oe, mclk, buzzer_out;
  logic signed [15:0] tone_sample, tx_path_sample;
  int                 errors = 0, samples_checked = 0, seed = 52840, w, n, mx;
  logic [15:0]        exp_q[$], got_q[$];
  string              name_q[$];
  event               got_e;
  logic [7:0]         rd;
  logic [5:0]         d;
  always #5 sys_clk = ~sys_clk;
  tbg_tone_ring_buzzer u_tbg_tone_ring_buzzer (.sys_clk(sys_clk), .rst(rst), .ctl_clk(ctl_clk),
    .ctl_cs_n(ctl_cs_n), .ctl_din(ctl_din), .ctl_dout(ctl_dout), .ctl_dout_oe(ctl_dout_oe),
    .mclk(mclk), .mclk_sel(mclk_sel), .pwr_down(pwr_down), .tx_amp_sample(tx_amp_sample),
    .tone_sample(tone_sample), .tx_path_sample(tx_path_sample), .buzzer_out(buzzer_out));
  tbg_far_side u_tbg_far_side (.mclk(mclk), .buzzer_out(buzzer_out));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic compare(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic note(input string nm, input logic [15:0] e, input logic [15:0] g);
    exp_q.push_back(e);
    name_q.push_back(nm);
    got_q.push_back(g);
    ->got_e;
  endtask
  always @(got_e) while (exp_q.size() > 0) compare(name_q.pop_front(), exp_q.pop_front(), got_q.pop_front());
  // Phases of 6 cycles leave room for the pin synchronisers
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] r);
    logic [15:0] sh;
    sh = {cmd, wd};
    ctl_cs_n = 1'b0;
    cyc(6);
    for (int k = 0; k < 16; k++) begin
      ctl_din = sh[15-k];
      cyc(6);
      if (k >= 8) r = {r[6:0], ctl_dout};
      if (k >= 8 && cmd[7]) note("dout enable", 16'h1, {15'h0, ctl_dout_oe});
      ctl_clk = 1'b1;
      cyc(6);
      ctl_clk = 1'b0;
    end
    cyc(6);
    ctl_cs_n = 1'b1;
    cyc(8);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    xfer({4'h0, a}, v, rd);
  endtask
  task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] e);
    xfer({4'h8, a}, 8'h00, rd);
    note(nm, {8'h00, e}, {8'h00, rd});
    note("dout released", 16'h0, {15'h0, ctl_dout_oe});
  endtask
  task automatic wait_lvl(input logic l);
    w = 0;
    while (buzzer_out !== l && w < 40000) begin
      cyc(1);
      w++;
    end
    if (w >= 40000) begin
      errors++;
      end_of_test();
    end
  endtask
  task automatic end_of_test();
    // Let the watcher drain pending notes
    #1;
    $display("Checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(6);
    rst = 1'b0;
    cyc(6);
    note("idle level", 16'h0000, {15'h0, buzzer_out});
    rdc("buzzer_control", REG_BUZZER_CONTROL, BUZZER_CTRL_RST);
    wr(REG_TONE_RANGE_SEL, 8'hFE);
    rdc("tone_range_select", REG_TONE_RANGE_SEL, 8'h02);
    rdc("unmapped", 4'h3, 8'h00);
    repeat (4) begin
      tx_amp_sample = 16'($random(seed));
      cyc(2);
      note("tx path", tx_amp_sample, tx_path_sample);
    end
    // Host sets all timing itself, one write at a time
    wr(REG_TONE_RANGE_SEL, 8'h00);
    wr(REG_FIRST_TONE_FREQ, 8'h80);
    rdc("first_tone_frequency", REG_FIRST_TONE_FREQ, 8'h80);
    wr(REG_TONE_CONTROL, 8'h08);
    note("tone level", 16'h3F80, tone_sample[15] ? -tone_sample : tone_sample);
    wr(REG_TONE_RANGE_SEL, 8'h02);
    wr(REG_TONE_RANGE_SEL, 8'h01);
    wr(REG_TONE_RANGE_SEL, 8'h00);
    for (int p = 0; p < 2; p++) begin
      d = 6'(1 + {$random(seed)} % 62);
      wr(REG_BUZZER_CONTROL, {1'b1, p[0], d});
      mx = 0;
      // Largest of three pulses skips any cut by the square window
      repeat (3) begin
        wait_lvl(~p[0]);
        n = 0;
        while (buzzer_out === ~p[0] && n < 40000) begin
          cyc(1);
          n++;
        end
        if (n >= 40000) begin
          errors++;
          end_of_test();
        end
        if (n > mx) mx = n;
      end
      note("pwm width", 16'h1, 16'(mx >= d * 40 - 3 && mx <= d * 40 + 3));
    end
    pwr_down = 1'b1;
    cyc(4);
    note("power down level", 16'h1, {15'h0, buzzer_out});
    pwr_down = 1'b0;
    wr(REG_BUZZER_CONTROL, {2'b01, d});
    note("disabled level", 16'h1, {15'h0, buzzer_out});
    wr(REG_SECOND_TONE_FREQ, 8'h40);
    wr(REG_TONE_CONTROL, 8'h00);
    wr(REG_BUZZER_CONTROL, {2'b10, d});
    // Both restart together; second stays low while first is high
    wr(REG_TONE_CONTROL, 8'h0C);
    n = 0;
    repeat (20000) begin
      cyc(1);
      if (buzzer_out !== 1'b0) n++;
    end
    note("am gate", 16'h0, 16'(n));
    wr(REG_TONE_CONTROL, 8'h29);
    note("tx tone", 16'h1FC0, tx_path_sample[15] ? -tx_path_sample : tx_path_sample);
    end_of_test();
  end
endmodule
